// file: rtl/lsc_map.vh
`ifndef LSC_MAP_VH
`define LSC_MAP_VH
// ----------------------------------------------------------------
// Command codes on op_code
// ----------------------------------------------------------------
`define LSC_OP_IDLE        4'h0
`define LSC_OP_IND_FETCH   4'h1
`define LSC_OP_OFS_FETCH   4'h2
`define LSC_OP_DIR_FETCH   4'h3
`define LSC_OP_IND_SAVE    4'h4
`define LSC_OP_OFS_SAVE    4'h5
`define LSC_OP_DIR_SAVE    4'h6
`define LSC_OP_CODE_FETCH  4'h7
`define LSC_OP_PORT_IN     4'h8
`define LSC_OP_PORT_OUT    4'h9
`define LSC_OP_PUSH        4'hA
`define LSC_OP_POP         4'hB
`define LSC_OP_SLEEP       4'hC
`define LSC_OP_WDOG        4'hD
`define LSC_OP_BREAK       4'hE
`define LSC_OP_CODE_WRITE  4'hF
// ----------------------------------------------------------------
// Pointer select and pointer mode
// ----------------------------------------------------------------
`define LSC_PTR_X          2'h0
`define LSC_PTR_Y          2'h1
`define LSC_PTR_Z          2'h2
`define LSC_MODE_PLAIN     2'h0
`define LSC_MODE_POST_INC  2'h1
`define LSC_MODE_PRE_DEC   2'h2
`define LSC_MODE_IMPLICIT  2'h3
// ----------------------------------------------------------------
// Register pair positions and reset values
// ----------------------------------------------------------------
`define LSC_GPR_X_LO       5'h1A
`define LSC_GPR_Y_LO       5'h1C
`define LSC_GPR_Z_LO       5'h1E
`define LSC_GPR_ZERO       5'h00
`define LSC_GPR_RESET      8'h00
`define LSC_SP_RESET       16'hFFFF
// ----------------------------------------------------------------
// Cycle counts
// ----------------------------------------------------------------
`define LSC_CYC_MEM        2
`define LSC_CYC_CODE       3
`define LSC_CYC_PORT       1
`endif

// file: rtl/lsc_ptr_unit.v
`timescale 1ns/1ps
`include "lsc_map.vh"
// ----------------------------------------------------------------
// Effective address and pointer update
// ----------------------------------------------------------------
module lsc_ptr_unit #(
  parameter DISP_W = 6
) (
  input  wire [15:0]       ptr,
  input  wire [1:0]        mode,
  input  wire              use_disp,
  input  wire [DISP_W-1:0] disp,
  output reg  [15:0]       ea,
  output reg  [15:0]       ptr_new,
  output reg               ptr_we
);
  wire [15:0] ptr_inc;
  wire [15:0] ptr_dec;
  wire [15:0] ptr_ofs;

  // Plain 16-bit sums so both ends wrap around
  assign ptr_inc = ptr + 16'h0001;
  assign ptr_dec = ptr - 16'h0001;
  assign ptr_ofs = ptr + {{(16-DISP_W){1'b0}}, disp};

  // Displacement never writes the pointer back
  always @* begin
    ea      = ptr;
    ptr_new = ptr;
    ptr_we  = 1'b0;
    if (use_disp) begin
      ea = ptr_ofs;
    end else begin
      case (mode)
        `LSC_MODE_POST_INC: begin
          ptr_new = ptr_inc;
          ptr_we  = 1'b1;
        end
        `LSC_MODE_PRE_DEC: begin
          ea      = ptr_dec;
          ptr_new = ptr_dec;
          ptr_we  = 1'b1;
        end
        default: begin
          ea = ptr;
        end
      endcase
    end
  end
endmodule

// file: rtl/lsc_regfile.v
`timescale 1ns/1ps
`include "lsc_map.vh"
// ----------------------------------------------------------------
// General purpose registers with pointer pair ports
// ----------------------------------------------------------------
module lsc_regfile #(
  parameter NREG = 32
) (
  input  wire        clk,
  input  wire        rst,
  input  wire        ce,
  input  wire        byte_we,
  input  wire [4:0]  byte_idx,
  input  wire [7:0]  byte_data,
  input  wire        ptr_we,
  input  wire [1:0]  ptr_wsel,
  input  wire [15:0] ptr_data,
  input  wire        ext_we,
  input  wire [4:0]  ext_idx,
  input  wire [7:0]  ext_data,
  input  wire [4:0]  rd_idx,
  output wire [7:0]  rd_data,
  input  wire [1:0]  ptr_rsel,
  output wire [15:0] ptr_val,
  input  wire [4:0]  peek_idx,
  output wire [7:0]  peek_data
);
  reg [7:0] gpr_reg [0:NREG-1];
  integer   i;

  // Low register of a pointer pair; high one is the next index
  function [4:0] lsc_ptr_lo;
    input [1:0] sel;
    begin
      case (sel)
        `LSC_PTR_X: lsc_ptr_lo = `LSC_GPR_X_LO;
        `LSC_PTR_Y: lsc_ptr_lo = `LSC_GPR_Y_LO;
        default:    lsc_ptr_lo = `LSC_GPR_Z_LO;
      endcase
    end
  endfunction

  wire [4:0] wlo;
  wire [4:0] rlo;
  assign wlo = lsc_ptr_lo(ptr_wsel);
  assign rlo = lsc_ptr_lo(ptr_rsel);

  // Pair forms the 16-bit pointer, high byte above low
  assign ptr_val   = {gpr_reg[rlo | 5'h01], gpr_reg[rlo]};
  assign rd_data   = gpr_reg[rd_idx];
  assign peek_data = gpr_reg[peek_idx];

  // Pointer port beats load data, which beats the outside port
  always @(posedge clk) begin
    for (i = 0; i < NREG; i = i + 1) begin
      if (rst) begin
        gpr_reg[i] <= `LSC_GPR_RESET;
      end else if (ce) begin
        if (ptr_we && wlo == i[4:0]) begin
          gpr_reg[i] <= ptr_data[7:0];
        end else if (ptr_we && (wlo | 5'h01) == i[4:0]) begin
          gpr_reg[i] <= ptr_data[15:8];
        end else if (byte_we && byte_idx == i[4:0]) begin
          gpr_reg[i] <= byte_data;
        end else if (ext_we && ext_idx == i[4:0]) begin
          gpr_reg[i] <= ext_data;
        end
      end
    end
  end
endmodule

// file: rtl/lsc_core.v
`timescale 1ns/1ps
`include "lsc_map.vh"
// Operation
// - Pre-decrement load via Y/Z: step pointer down, load, two cycles.
// - Offset load reads pointer plus offset, pointer kept, two cycles.
// - Post-increment load via Z: load at pointer, then pointer plus one.
// - Direct load reads the absolute address from the command, two cycles.
// - Post-increment store writes at pointer, then steps it, two cycles.
// - Pre-decrement store steps pointer down, writes there, two cycles.
// - Displacement store writes at pointer plus offset, pointer kept.
// - Direct store writes to the absolute command address, two cycles.
// - Code memory fetch takes three cycles into named reg or gpr_zero.
// - Port read and port write each complete in one cycle.
// - Stack push and pop each take two cycles.
// - Sleep issues in one cycle, signals sleep logic, flags untouched.
// - Watchdog restart issues in one cycle and pulses the watchdog.
// - Debug break only halts for the debugger; no fixed length.
module lsc_core #(
  parameter IO_AW    = 6,
  parameter DISP_W   = 6,
  parameter SP_RESET = `LSC_SP_RESET
) (
  input  wire              clk,
  input  wire              rst,
  input  wire              ce,
  input  wire              op_valid,
  input  wire [3:0]        op_code,
  input  wire [1:0]        op_ptr,
  input  wire [1:0]        op_mode,
  input  wire [4:0]        op_reg,
  input  wire [DISP_W-1:0] op_disp,
  input  wire [15:0]       op_addr,
  input  wire [IO_AW-1:0]  op_io,
  input  wire              dbg_resume,
  input  wire [7:0]        dmem_rdata,
  input  wire [7:0]        pmem_rdata,
  input  wire [7:0]        io_rdata,
  input  wire              ext_we,
  input  wire [4:0]        ext_idx,
  input  wire [7:0]        ext_data,
  input  wire [4:0]        peek_idx,
  output reg               op_ready,
  output reg  [15:0]       dmem_addr,
  output reg  [7:0]        dmem_wdata,
  output reg               dmem_we,
  output reg               dmem_re,
  output reg  [15:0]       pmem_addr,
  output reg               pmem_re,
  output reg  [IO_AW-1:0]  io_addr,
  output reg  [7:0]        io_wdata,
  output reg               io_we,
  output reg               io_re,
  output reg               sleep_req,
  output reg               wdog_req,
  output reg               brk_active,
  output reg               sreg_we,
  output reg  [15:0]       sp,
  output reg  [7:0]        peek_data
);
  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam ST_IDLE  = 3'd0;
  localparam ST_HOLD  = 3'd1;
  localparam ST_DLD1  = 3'd2;
  localparam ST_DLD2  = 3'd3;
  localparam ST_CODE1 = 3'd4;
  localparam ST_CODE2 = 3'd5;
  localparam ST_CODE3 = 3'd6;
  localparam ST_BRK   = 3'd7;
  localparam ST_W     = 3;

  reg [ST_W-1:0] state_reg;
  reg            io_wb_reg;
  reg [4:0]      dst_reg;

  // ----------------------------------------------------------------
  // Register file and pointer arithmetic
  // ----------------------------------------------------------------
  wire        accept;
  wire        is_code;
  wire        is_ofs;
  wire [1:0]  ptr_rsel;
  wire [15:0] ptr_val;
  wire [15:0] ea;
  wire [15:0] ptr_new;
  wire        ptr_upd;
  wire [7:0]  src_data;
  wire [7:0]  peek_val;
  wire        byte_we;
  reg  [7:0]  byte_data;
  wire        ptr_we;
  wire [15:0] sp_inc;
  wire [15:0] sp_dec;

  assign accept   = ce & op_valid & op_ready;
  assign is_code  = (op_code == `LSC_OP_CODE_FETCH);
  assign is_ofs   = (op_code == `LSC_OP_OFS_FETCH) |
                    (op_code == `LSC_OP_OFS_SAVE);
  // Code memory is always addressed through Z
  assign ptr_rsel = is_code ? `LSC_PTR_Z : op_ptr;
  assign sp_inc   = sp + 16'h0001;
  assign sp_dec   = sp - 16'h0001;

  // Pointer write only for the commands that walk a pointer
  assign ptr_we = accept & ptr_upd &
                  ((op_code == `LSC_OP_IND_FETCH) |
                   (op_code == `LSC_OP_IND_SAVE) | is_code);

  // Result lands on the final edge of the command
  assign byte_we = ce & ((state_reg == ST_DLD2) |
                         (state_reg == ST_CODE3) | io_wb_reg);

  // Source of the result byte
  always @* begin
    byte_data = dmem_rdata;
    if (state_reg == ST_CODE3) begin
      byte_data = pmem_rdata;
    end else if (io_wb_reg) begin
      byte_data = io_rdata;
    end
  end

  lsc_ptr_unit #(
    .DISP_W   (DISP_W)
  ) u_ptr (
    .ptr      (ptr_val),
    .mode     (op_mode),
    .use_disp (is_ofs),
    .disp     (op_disp),
    .ea       (ea),
    .ptr_new  (ptr_new),
    .ptr_we   (ptr_upd)
  );

  lsc_regfile #(
    .NREG      (32)
  ) u_gpr (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .byte_we   (byte_we),
    .byte_idx  (dst_reg),
    .byte_data (byte_data),
    .ptr_we    (ptr_we),
    .ptr_wsel  (ptr_rsel),
    .ptr_data  (ptr_new),
    .ext_we    (ext_we),
    .ext_idx   (ext_idx),
    .ext_data  (ext_data),
    .rd_idx    (op_reg),
    .rd_data   (src_data),
    .ptr_rsel  (ptr_rsel),
    .ptr_val   (ptr_val),
    .peek_idx  (peek_idx),
    .peek_data (peek_val)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Strobes are one-cycle; a new command may start on the last edge
  // of the previous one, since write-back uses the old state.
  always @(posedge clk) begin
    if (rst) begin
      state_reg  <= ST_IDLE;
      io_wb_reg  <= 1'b0;
      dst_reg    <= 5'h00;
      op_ready   <= 1'b1;
      dmem_addr  <= 16'h0000;
      dmem_wdata <= 8'h00;
      dmem_we    <= 1'b0;
      dmem_re    <= 1'b0;
      pmem_addr  <= 16'h0000;
      pmem_re    <= 1'b0;
      io_addr    <= {IO_AW{1'b0}};
      io_wdata   <= 8'h00;
      io_we      <= 1'b0;
      io_re      <= 1'b0;
      sleep_req  <= 1'b0;
      wdog_req   <= 1'b0;
      brk_active <= 1'b0;
      sreg_we    <= 1'b0;
      sp         <= SP_RESET;
      peek_data  <= 8'h00;
    end else if (ce) begin
      dmem_we   <= 1'b0;
      dmem_re   <= 1'b0;
      pmem_re   <= 1'b0;
      io_we     <= 1'b0;
      io_re     <= 1'b0;
      sleep_req <= 1'b0;
      wdog_req  <= 1'b0;
      io_wb_reg <= 1'b0;
      sreg_we   <= 1'b0;
      peek_data <= peek_val;
      // Progress of the command in flight
      case (state_reg)
        ST_HOLD: begin
          op_ready  <= 1'b1;
          state_reg <= ST_IDLE;
        end
        ST_DLD1: begin
          op_ready  <= 1'b1;
          state_reg <= ST_DLD2;
        end
        ST_CODE1: begin
          pmem_re   <= 1'b1;
          state_reg <= ST_CODE2;
        end
        ST_CODE2: begin
          op_ready  <= 1'b1;
          state_reg <= ST_CODE3;
        end
        ST_BRK: begin
          // Held until the debugger lets go
          if (dbg_resume) begin
            brk_active <= 1'b0;
            op_ready   <= 1'b1;
            state_reg  <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
      // A new command overrides the idle transition above
      if (accept) begin
        case (op_code)
          `LSC_OP_IND_FETCH, `LSC_OP_OFS_FETCH: begin
            dmem_addr <= ea;
            dmem_re   <= 1'b1;
            dst_reg   <= op_reg;
            op_ready  <= 1'b0;
            state_reg <= ST_DLD1;
          end
          `LSC_OP_DIR_FETCH: begin
            dmem_addr <= op_addr;
            dmem_re   <= 1'b1;
            dst_reg   <= op_reg;
            op_ready  <= 1'b0;
            state_reg <= ST_DLD1;
          end
          `LSC_OP_IND_SAVE, `LSC_OP_OFS_SAVE: begin
            dmem_addr  <= ea;
            dmem_wdata <= src_data;
            dmem_we    <= 1'b1;
            op_ready   <= 1'b0;
            state_reg  <= ST_HOLD;
          end
          `LSC_OP_DIR_SAVE: begin
            dmem_addr  <= op_addr;
            dmem_wdata <= src_data;
            dmem_we    <= 1'b1;
            op_ready   <= 1'b0;
            state_reg  <= ST_HOLD;
          end
          `LSC_OP_CODE_FETCH: begin
            pmem_addr <= ptr_val;
            dst_reg   <= (op_mode == `LSC_MODE_IMPLICIT) ?
                         `LSC_GPR_ZERO : op_reg;
            op_ready  <= 1'b0;
            state_reg <= ST_CODE1;
          end
          `LSC_OP_PORT_IN: begin
            io_addr   <= op_io;
            io_re     <= 1'b1;
            io_wb_reg <= 1'b1;
            dst_reg   <= op_reg;
          end
          `LSC_OP_PORT_OUT: begin
            io_addr  <= op_io;
            io_wdata <= src_data;
            io_we    <= 1'b1;
          end
          `LSC_OP_PUSH: begin
            // Post-decrement stack: write, then step down
            dmem_addr  <= sp;
            dmem_wdata <= src_data;
            dmem_we    <= 1'b1;
            sp         <= sp_dec;
            op_ready   <= 1'b0;
            state_reg  <= ST_HOLD;
          end
          `LSC_OP_POP: begin
            // Pre-increment stack: step up, then read
            dmem_addr <= sp_inc;
            dmem_re   <= 1'b1;
            sp        <= sp_inc;
            dst_reg   <= op_reg;
            op_ready  <= 1'b0;
            state_reg <= ST_DLD1;
          end
          `LSC_OP_SLEEP: begin
            sleep_req <= 1'b1;
          end
          `LSC_OP_WDOG: begin
            wdog_req <= 1'b1;
          end
          `LSC_OP_BREAK: begin
            brk_active <= 1'b1;
            op_ready   <= 1'b0;
            state_reg  <= ST_BRK;
          end
          default: begin
            // Idle op and code write: one cycle, no effect
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule

// file: verif/lsc_mem_model.sv
`timescale 1ns/1ps
// ------
// Data, code and port space seen by the core
// ------
module lsc_mem_model (
  input  wire        clk,
  input  wire [15:0] dmem_addr,
  input  wire        dmem_re,
  input  wire [15:0] pmem_addr,
  input  wire        pmem_re,
  input  wire [5:0]  io_addr,
  input  wire        io_re,
  output logic [7:0] dmem_rdata = 8'h00,
  output logic [7:0] pmem_rdata = 8'h00,
  output wire  [7:0] io_rdata
);
  logic [7:0] junk = 8'h00;
  // Fixed patterns stand in for contents, so no big arrays are needed
  function automatic [7:0] dval(input [15:0] a);
    return a[15:8] ^ a[7:0] ^ 8'hA5;
  endfunction
  function automatic [7:0] pval(input [15:0] a);
    return a[15:8] + a[7:0] + 8'h3C;
  endfunction
  function automatic [7:0] ival(input [5:0] a);
    return ~{a, 2'h2};
  endfunction
  // Data one cycle after the strobe; otherwise inverted, never held
  always @(posedge clk) begin
    dmem_rdata <= dmem_re ? dval(dmem_addr) : ~dmem_rdata;
    pmem_rdata <= pmem_re ? pval(pmem_addr) : ~pmem_rdata;
    junk       <= junk + 8'h4B;
  end
  // Port data valid only within the strobe cycle
  assign io_rdata = io_re ? ival(io_addr) : junk;
endmodule

// file: verif/lsc_core_sva.sv
`timescale 1ns/1ps
`include "lsc_map.vh"
// ------
// Command timing checks
// ------
module lsc_core_sva (
  input wire        clk,
  input wire        rst,
  input wire        ce,
  input wire        op_valid,
  input wire [3:0]  op_code,
  input wire        op_ready,
  input wire        dmem_re,
  input wire        dmem_we,
  input wire        pmem_re,
  input wire        io_re,
  input wire        io_we,
  input wire        sleep_req,
  input wire        wdog_req,
  input wire        brk_active,
  input wire        sreg_we,
  input wire [15:0] sp
);
  // Taken commands by class
  wire acc = op_valid && op_ready && ce;
  wire fetch_cmd = acc && op_code inside {`LSC_OP_IND_FETCH,
    `LSC_OP_OFS_FETCH, `LSC_OP_DIR_FETCH, `LSC_OP_POP};
  wire save_cmd = acc && op_code inside {`LSC_OP_IND_SAVE,
    `LSC_OP_OFS_SAVE, `LSC_OP_DIR_SAVE, `LSC_OP_PUSH};
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  fetch_time_a: assert property (
    fetch_cmd ##1 ce |-> dmem_re && !op_ready ##1 !dmem_re && op_ready)
    else $error("data fetch strobe or length wrong");
  save_time_a: assert property (
    save_cmd ##1 ce |-> dmem_we && !dmem_re && !op_ready ##1 !dmem_we
    && op_ready) else $error("data save strobe or length wrong");
  code_time_a: assert property (
    acc && op_code == `LSC_OP_CODE_FETCH ##1 ce ##1 ce |-> pmem_re
    && !op_ready ##1 op_ready && !pmem_re) else $error("code fetch length");
  port_one_a: assert property (
    acc && op_code inside {`LSC_OP_PORT_IN, `LSC_OP_PORT_OUT} |=> op_ready
    && io_re != io_we) else $error("port transfer not one cycle");
  push_step_a: assert property (
    acc && op_code == `LSC_OP_PUSH |=> sp == $past(sp) - 16'h0001)
    else $error("stack pointer step on push wrong");
  sleep_issue_a: assert property (
    acc && op_code == `LSC_OP_SLEEP |=> sleep_req && op_ready)
    else $error("sleep request missing");
  wdog_cause_a: assert property (
    wdog_req && $past(ce) |-> $past(acc) && $past(op_code) == `LSC_OP_WDOG)
    else $error("watchdog request without command");
  flags_kept_a: assert property (!sreg_we)
    else $error("status flags written");
  break_hold_a: assert property (
    acc && op_code == `LSC_OP_BREAK |=> brk_active && !op_ready)
    else $error("debug break not held");
endmodule
bind lsc_core lsc_core_sva u_sva (
  .clk(clk), .rst(rst), .ce(ce), .op_valid(op_valid), .op_code(op_code),
  .op_ready(op_ready), .dmem_re(dmem_re), .dmem_we(dmem_we),
  .pmem_re(pmem_re), .io_re(io_re), .io_we(io_we), .sleep_req(sleep_req),
  .wdog_req(wdog_req), .brk_active(brk_active), .sreg_we(sreg_we), .sp(sp)
);

// file: verif/lsc_core_tb.sv
`timescale 1ns/1ps
`include "lsc_map.vh"
module lsc_core_tb;
  // ------
  // Stimulus, shadow state and bench
  // ------
  logic        clk = '0, rst = 1'h1, ce = 1'h1, op_valid = '0;
  logic        dbg_resume = '0, ext_we = '0, pok = '0;
  logic [3:0]  op_code = '0, c;
  logic [1:0]  op_ptr = '0, op_mode = '0, m, p;
  logic [4:0]  op_reg = '0, ext_idx = '0, peek_idx = '0, pi;
  logic [5:0]  op_disp = '0, op_io = '0;
  logic [15:0] op_addr = '0, ssp = `LSC_SP_RESET;
  logic [7:0]  ext_data = '0, pd, g [32];
  logic [31:0] seed = 32'h00014EC6, r;
  logic [27:0] q [$];
  int          n_errors = 0, n_tests = 0, cyc = 0, lacc = 0, ln = 0;
  wire  [7:0]  dmem_rdata, pmem_rdata, io_rdata, dmem_wdata, io_wdata;
  wire  [7:0]  peek_data;
  wire  [15:0] dmem_addr, pmem_addr, sp;
  wire  [5:0]  io_addr;
  wire         op_ready, dmem_we, dmem_re, pmem_re, io_we, io_re;
  wire         sleep_req, wdog_req, brk_active, sreg_we;
  lsc_core      uut (.*);
  lsc_mem_model mdl (.*);
  initial forever #4 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  function automatic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk_evt(input logic [27:0] got);
    logic [27:0] e;
    e = q.size() > 0 ? q.pop_front() : 28'h0000000;
    n_tests++;
    if (got !== e) begin
      n_errors++;
      $display("[FAIL] %0t event %h expected %h", $time, got, e);
    end
  endtask
  task automatic chk_val(input logic [15:0] got, input logic [15:0] e);
    n_tests++;
    if (got !== e) begin
      n_errors++;
      $display("[FAIL] %0t value %h expected %h", $time, got, e);
    end
  endtask
  task automatic peek(input logic [4:0] i, input logic [7:0] e);
    peek_idx <= i;
    repeat (2) @(posedge clk);
    chk_val({8'h00, peek_data}, {8'h00, e});
  endtask
  // Load results land on the next command's edge, so apply them late
  task automatic drain();
    op_valid <= 1'h0;
    ln = 0;
    repeat (4) @(posedge clk);
    if (pok) g[pi] = pd;
    pok = 1'h0;
  endtask
  task automatic issue(input logic [3:0] c, input logic [1:0] p, m,
                       input logic [4:0] r, input logic [15:0] a);
    logic [4:0]  l, d;
    logic [15:0] pv, ea;
    logic [7:0]  v;
    logic        w, dw;
    int          n;
    l = 5'h1A + {2'h0, p, 1'h0};
    pv = {g[l+1], g[l]};
    w = c inside {`LSC_OP_IND_FETCH, `LSC_OP_IND_SAVE, `LSC_OP_CODE_FETCH};
    if (w && m == `LSC_MODE_PRE_DEC) pv = pv - 16'h0001;
    ea = c inside {`LSC_OP_DIR_FETCH, `LSC_OP_DIR_SAVE} ? a :
         c inside {`LSC_OP_OFS_FETCH, `LSC_OP_OFS_SAVE} ? pv + a[5:0] : pv;
    if (w && m == `LSC_MODE_POST_INC) pv = pv + 16'h0001;
    n = 2;
    d = r;
    v = 8'h00;
    dw = c inside {`LSC_OP_IND_FETCH, `LSC_OP_OFS_FETCH, `LSC_OP_DIR_FETCH,
      `LSC_OP_CODE_FETCH, `LSC_OP_PORT_IN, `LSC_OP_POP};
    case (c)
      `LSC_OP_IND_FETCH, `LSC_OP_OFS_FETCH, `LSC_OP_DIR_FETCH: begin
        q.push_back({4'h1, ea, 8'h00});
        v = mdl.dval(ea);
      end
      `LSC_OP_IND_SAVE, `LSC_OP_OFS_SAVE, `LSC_OP_DIR_SAVE:
        q.push_back({4'h2, ea, g[r]});
      `LSC_OP_CODE_FETCH: begin
        q.push_back({4'h3, ea, 8'h00});
        n = 3;
        v = mdl.pval(ea);
        if (m == `LSC_MODE_IMPLICIT) d = `LSC_GPR_ZERO;
      end
      `LSC_OP_PORT_IN: begin
        q.push_back({4'h4, 10'h000, a[5:0], 8'h00});
        n = 1;
        v = mdl.ival(a[5:0]);
      end
      `LSC_OP_PORT_OUT: begin
        q.push_back({4'h5, 10'h000, a[5:0], g[r]});
        n = 1;
      end
      `LSC_OP_PUSH: begin
        q.push_back({4'h2, ssp, g[r]});
        ssp = ssp - 16'h0001;
      end
      `LSC_OP_POP: begin
        ssp = ssp + 16'h0001;
        q.push_back({4'h1, ssp, 8'h00});
        v = mdl.dval(ssp);
      end
      `LSC_OP_SLEEP: begin
        q.push_back({4'h6, 24'h000000});
        n = 1;
      end
      `LSC_OP_WDOG: begin
        q.push_back({4'h7, 24'h000000});
        n = 1;
      end
      `LSC_OP_BREAK: n = 0;
      default: n = 1;
    endcase
    {g[l+1], g[l]} = pv;
    if (pok) g[pi] = pd;
    pok = dw;
    pi = d;
    pd = v;
    op_valid <= 1'h1;
    op_code <= c;
    op_ptr <= p;
    op_mode <= m;
    op_reg <= r;
    op_disp <= a[5:0];
    op_addr <= a;
    op_io <= a[5:0];
    @(posedge clk);
    for (int k = 0; k < 20 && op_ready !== 1'h1; k++) @(posedge clk);
    if (ln > 0) chk_val(16'(cyc - lacc), 16'(ln));
    lacc = cyc;
    ln = n;
  endtask
  task automatic test_done();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Each strobe counts once, at the edge where the clock enable is high
  always @(posedge clk) if (ce === 1'h1) begin
    if (dmem_re === 1'h1) chk_evt({4'h1, dmem_addr, 8'h00});
    if (dmem_we === 1'h1) chk_evt({4'h2, dmem_addr, dmem_wdata});
    if (pmem_re === 1'h1) chk_evt({4'h3, pmem_addr, 8'h00});
    if (io_re === 1'h1) chk_evt({4'h4, 10'h000, io_addr, 8'h00});
    if (io_we === 1'h1) chk_evt({4'h5, 10'h000, io_addr, io_wdata});
    if (sleep_req === 1'h1) chk_evt({4'h6, 24'h000000});
    if (wdog_req === 1'h1) chk_evt({4'h7, 24'h000000});
  end
  initial begin
    repeat (6000) @(posedge clk);
    n_errors++;
    $display("watchdog expired");
    test_done();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    repeat (2) @(posedge clk);
    chk_val(sp, `LSC_SP_RESET);
    chk_val({14'h0000, op_ready, sreg_we}, 16'h0002);
    $display("reset test done");
    // Y starts at 0000 and Z at FFFF to reach both wrap ends
    for (int i = 0; i < 32; i++) begin
      r = rnd();
      g[i] = i > 27 ? {8{i[1]}} : r[7:0];
      ext_we <= 1'h1;
      ext_idx <= 5'(i);
      ext_data <= g[i];
      @(posedge clk);
    end
    ext_we <= 1'h0;
    issue(`LSC_OP_IND_FETCH, `LSC_PTR_Y, `LSC_MODE_PRE_DEC, 5'h03,
          16'h0000);
    issue(`LSC_OP_IND_SAVE, `LSC_PTR_Z, `LSC_MODE_POST_INC, 5'h03,
          16'h0000);
    issue(`LSC_OP_POP, 2'h0, 2'h0, 5'h05, 16'h0000);
    for (int i = 0; i < 300; i++) begin
      r = rnd();
      c = r[3:0] == `LSC_OP_BREAK ? `LSC_OP_IDLE : r[3:0];
      m = r[5:4] == 2'h3 ? `LSC_MODE_PLAIN : r[5:4];
      if (c == `LSC_OP_CODE_FETCH && r[5]) m = `LSC_MODE_IMPLICIT;
      if (!(c inside {`LSC_OP_IND_FETCH, `LSC_OP_IND_SAVE,
            `LSC_OP_CODE_FETCH})) m = `LSC_MODE_PLAIN;
      p = c == `LSC_OP_CODE_FETCH || r[7:6] == 2'h3 ? `LSC_PTR_Z : r[7:6];
      issue(c, p, m, 5'(r[12:8] % 26), r[31:16]);
    end
    drain();
    $display("command test done");
    issue(`LSC_OP_BREAK, 2'h0, 2'h0, 5'h00, 16'h0000);
    op_valid <= 1'h0;
    repeat (4) @(posedge clk);
    chk_val({14'h0000, brk_active, op_ready}, 16'h0002);
    dbg_resume <= 1'h1;
    @(posedge clk);
    dbg_resume <= 1'h0;
    @(posedge clk);
    chk_val({14'h0000, brk_active, op_ready}, 16'h0001);
    // A stalled push must still write exactly once
    issue(`LSC_OP_PUSH, 2'h0, 2'h0, 5'h07, 16'h0000);
    ce <= 1'h0;
    repeat (3) @(posedge clk);
    ce <= 1'h1;
    drain();
    $display("break and stall test done");
    for (int i = 0; i < 32; i++) peek(5'(i), g[i]);
    chk_val(sp, ssp);
    chk_val(16'(q.size()), 16'h0000);
    $display("register test done");
    test_done();
  end
endmodule
